// File: hdl/sfcfe_buf.sv
// Two-entry buffer with valid/ready on both sides; outputs are flops.
// Assumes the drain may stall for any number of cycles.
`timescale 1ns/1ps
`default_nettype none
module sfcfe_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  logic [W-1:0] d1_q;
  logic         v1_q;
  logic         pop;
  logic         push;
  assign pop      = out_valid & out_ready;
  assign push     = in_valid & in_ready;
  assign in_ready = ~v1_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
      v1_q      <= 1'b0;
      d1_q      <= '0;
    end
    else
    begin
      if (!out_valid || pop)
      begin
        if (v1_q)
        begin
          out_valid <= 1'b1;
          out_data  <= d1_q;
          v1_q      <= push;
          d1_q      <= in_data;
        end
        else
        begin
          out_valid <= push;
          out_data  <= in_data;
        end
      end
      else if (push)
      begin
        v1_q <= 1'b1;
        d1_q <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/sfcfe_pkg.sv
// Types shared by the command front end modules.
// Assumes sfcfe_regs.svh is on the include path.
`include "sfcfe_regs.svh"
package sfcfe_pkg;
  typedef logic [7:0] sfcfe_byte_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_IN   = 2'b01,
    PH_OUT  = 2'b10
  } sfcfe_phase_t;
endpackage

// File: hdl/sfcfe_regs.svh
// Constants of the serial flash command front end: opcodes, frame lengths
// and field widths. Included by the package, the top module, the checker and the bench.
`ifndef SFCFE_REGS_SVH
`define SFCFE_REGS_SVH
`define SFCFE_OP_WR_ARM     8'h06
`define SFCFE_OP_WR_DISARM  8'h04
`define SFCFE_OP_STAT_STORE 8'h01
`define SFCFE_OP_PAGE_WR    8'h02
`define SFCFE_OP_PAGE_WR4   8'h32
`define SFCFE_OP_WIPE_4K    8'h20
`define SFCFE_OP_WIPE_HALF  8'h52
`define SFCFE_OP_WIPE_LARGE 8'hD8
`define SFCFE_OP_WIPE_ALL_A 8'hC7
`define SFCFE_OP_WIPE_ALL_B 8'h60
`define SFCFE_OP_LP_ENTRY   8'hB9
`define SFCFE_OP_WAKE       8'hAB
`define SFCFE_OP_STAT_RD    8'h05
`define SFCFE_OP_SUSP_RD    8'h09
`define SFCFE_OP_RST_ARM    8'h66
`define SFCFE_OP_RST        8'h99
`define SFCFE_OP_LANE4_IN   8'h38
`define SFCFE_OP_LANE4_OUT  8'hFF
`define SFCFE_OP_RD         8'h03
`define SFCFE_OP_RD_FAST    8'h0B
`define SFCFE_OP_RD_2OUT    8'h3B
`define SFCFE_OP_RD_2IO     8'hBB
`define SFCFE_OP_RD_4OUT    8'h6B
`define SFCFE_OP_RD_4IO     8'hEB
`define SFCFE_BITS_W        16
`define SFCFE_BYTE_IDX_W    13
`define SFCFE_LEN_OP        13'h0001
`define SFCFE_LEN_ADDR      13'h0004
`define SFCFE_LEN_DUMMY     13'h0005
`define SFCFE_LEN_PW_MIN    13'h0005
`define SFCFE_LEN_STAT_MIN  13'h0002
`define SFCFE_LEN_FF_BITS   16'h0008
`define SFCFE_STEP_1        16'h0001
`define SFCFE_STEP_4        16'h0004
`define SFCFE_OUT_LAST      3'h7
`define SFCFE_STAT_RESET    8'h00
`endif

// File: hdl/sfcfe_sync.sv
// Two-flop synchroniser for a bundle of single-bit levels.
// Assumes each bit is an independent level from another domain.
`timescale 1ns/1ps
`default_nettype none
module sfcfe_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '1;
      dout   <= '1;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: hdl/sfcfe_top.sv
// Command front end of a small serial flash: frames host commands, checks
// them at deselect, streams read data and passes page data to the engine.
// Assumes the serial pins are asynchronous to CLK_SYS and the serial clock
// runs well below a quarter of CLK_SYS; the engine shares CLK_SYS.
// Functional notes
// - All serial fields travel MSB first.
// - Sample input on each rising serial clock.
// - Frame opens with one opcode byte.
// - Read-type commands get an output phase.
// - Write-class commands need byte-aligned deselect.
// - Partial page write byte: no program, arm kept.
// - Too-short page write or status store ignored.
// - Page write needs four bytes after opcode.
// - Wipes need exactly three address bytes; full wipes need none.
// - Array access ignored while engine busy.
// - Reset executes only right after reset arm.
// - Lane exit: eight or two clocks.
// - Status reads repeat byte until deselect.
// - Returned data driven MSB first on output.
// - Arm latch cleared after write-class completion.
// - Low power: only wake is honoured.
// - Lane entry switches to four-lane frames.
// - Software reset zeroes both status bytes.
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_regs.svh"
module sfcfe_top
  import sfcfe_pkg::*;
#(
  parameter sfcfe_byte_t WAKE_ID = 8'h5A  // Arbitrary identifier value
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // Serial link
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_SCK,
  input  wire logic        SERIAL_IN_LINE,
  input  wire logic [2:0]  DQ_HI_IN,
  output var  logic        SERIAL_OUT,
  output var  logic        SERIAL_OUT_OE_N,
  // Engine command
  input  wire logic        ENGINE_BUSY,
  output var  logic        EXEC_VALID,
  output var  logic [7:0]  EXEC_OP,
  output var  logic [23:0] EXEC_ADDR,
  output var  logic [7:0]  EXEC_STATUS,
  // Page data stream
  output var  logic        WR_VALID,
  input  wire logic        WR_READY,
  output var  logic [7:0]  WR_DATA,
  // Array read port
  output var  logic [23:0] RD_ADDR,
  input  wire logic [7:0]  ARRAY_DATA,
  // Suspend flags
  input  wire logic [7:0]  SUSP_SET,
  // Status
  output var  logic        WRITE_ARM_LATCH,
  output var  logic        LOW_POWER,
  output var  logic        FOUR_LANE_MODE,
  output var  logic        SOFT_RESET,
  output var  logic        CMD_REJECT
);
  logic [5:0]              sync_out;
  logic                    cs_n_s;
  logic                    sck_s;
  logic [3:0]              din_s;
  logic                    sck_p_q;
  logic                    cs_p_q;
  logic                    rise;
  logic                    fall;
  logic                    start;
  logic                    stop;
  sfcfe_phase_t            phase_q;
  logic [`SFCFE_BITS_W-1:0] bits_q;
  logic [`SFCFE_BITS_W-1:0] bits_d;
  logic [7:0]              sh_q;
  logic [7:0]              sh_d;
  logic                    byte_done;
  logic [`SFCFE_BYTE_IDX_W-1:0] idx;
  logic [`SFCFE_BYTE_IDX_W-1:0] nbytes;
  logic [7:0]              op_q;
  logic [7:0]              op_now;
  logic [23:0]             addr_q;
  logic [7:0]              dat_q;
  logic [`SFCFE_BYTE_IDX_W-1:0] out_at;
  logic [7:0]              osh_q;
  logic [2:0]              ocnt_q;
  logic [7:0]              next_out;
  logic [7:0]              stat_q;
  logic [7:0]              susp_q;
  logic                    arm_q;
  logic                    ovr_q;
  logic                    busy;
  logic                    aligned;
  logic                    pw_ok;
  logic                    push;
  logic                    buf_ready;
  logic [7:0]              status_byte;
  logic                    acc;
  logic                    rej;
  logic                    do_exec;
  logic                    do_arm;
  logic                    do_disarm;
  logic                    do_lp;
  logic                    do_wake;
  logic                    do_q_in;
  logic                    do_q_out;
  logic                    do_rst_arm;
  logic                    do_rst;
  logic                    do_stat;

  sfcfe_sync #(
    .W (6)
  ) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .din   ({SPI_CS_N, SPI_SCK, DQ_HI_IN, SERIAL_IN_LINE}),
    .dout  (sync_out)
  );

  assign cs_n_s = sync_out[5];
  assign sck_s  = sync_out[4];
  assign din_s  = sync_out[3:0];
  assign rise   = sck_s & ~sck_p_q & ~cs_n_s;
  assign fall   = ~sck_s & sck_p_q & ~cs_n_s;
  assign start  = ~cs_n_s & cs_p_q;
  assign stop   = cs_n_s & ~cs_p_q;

  // Edge finder on the synchronised serial clock and select
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sck_p_q <= 1'b0;
      cs_p_q  <= 1'b1;
    end
    else
    begin
      sck_p_q <= sck_s;
      cs_p_q  <= cs_n_s;
    end
  end

  // Input shifter: one bit per clock, or a nibble in four-lane mode
  always_comb
  begin
    if (FOUR_LANE_MODE)
    begin
      bits_d = bits_q + `SFCFE_STEP_4;
      sh_d   = {sh_q[3:0], din_s[3:0]};
    end
    else
    begin
      bits_d = bits_q + `SFCFE_STEP_1;
      sh_d   = {sh_q[6:0], din_s[0]};
    end
  end

  assign byte_done = rise & (bits_d[2:0] == 3'h0);
  assign idx       = bits_q[`SFCFE_BITS_W-1:3];
  assign nbytes    = bits_q[`SFCFE_BITS_W-1:3];
  assign aligned   = (bits_q[2:0] == 3'h0);
  assign op_now    = (idx == '0) ? sh_d : op_q;
  assign busy      = ENGINE_BUSY | EXEC_VALID;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bits_q <= '0;
      sh_q   <= '0;
    end
    else if (start)
    begin
      bits_q <= '0;
      sh_q   <= '0;
    end
    else if (rise && (bits_q != '1))
    begin
      bits_q <= bits_d;
      sh_q   <= sh_d;
    end
  end

  // Opcode, address and first data byte capture
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      op_q   <= '0;
      addr_q <= '0;
      dat_q  <= '0;
    end
    else if (byte_done)
    begin
      if (idx == '0)
        op_q <= sh_d;
      if ((idx != '0) && (idx < `SFCFE_LEN_ADDR))
        addr_q <= {addr_q[15:0], sh_d};
      if (idx == `SFCFE_LEN_OP)
        dat_q <= sh_d;
    end
  end

  // Input length after which a read-type command starts returning data
  always_comb
  begin
    out_at = '0;
    if (!LOW_POWER)
    begin
      case (op_now)
        `SFCFE_OP_STAT_RD,
        `SFCFE_OP_SUSP_RD:   out_at = `SFCFE_LEN_OP;
        `SFCFE_OP_WAKE:      out_at = `SFCFE_LEN_ADDR;
        `SFCFE_OP_RD:        out_at = busy ? '0 : `SFCFE_LEN_ADDR;
        `SFCFE_OP_RD_FAST,
        `SFCFE_OP_RD_2OUT,
        `SFCFE_OP_RD_2IO,
        `SFCFE_OP_RD_4OUT,
        `SFCFE_OP_RD_4IO:    out_at = busy ? '0 : `SFCFE_LEN_DUMMY;
        default:             out_at = '0;
      endcase
    end
    else if (op_now == `SFCFE_OP_WAKE)
      out_at = `SFCFE_LEN_ADDR;
  end

  // Frame phase
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      phase_q <= PH_IDLE;
    else if (cs_n_s)
      phase_q <= PH_IDLE;
    else
    begin
      unique case (phase_q)
        PH_IDLE: phase_q <= PH_IN;
        PH_IN:
          if (byte_done && (out_at != '0) && (idx + `SFCFE_LEN_OP == out_at))
            phase_q <= PH_OUT;
        PH_OUT:  phase_q <= PH_OUT;
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  assign status_byte = {stat_q[7:2], WRITE_ARM_LATCH, busy};
  always_comb
  begin
    case (op_q)
      `SFCFE_OP_STAT_RD: next_out = status_byte;
      `SFCFE_OP_SUSP_RD: next_out = susp_q;
      `SFCFE_OP_WAKE:    next_out = WAKE_ID;
      default:           next_out = ARRAY_DATA;
    endcase
  end

  // Output shifter, driven on falling serial clock edges
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SERIAL_OUT      <= 1'b0;
      SERIAL_OUT_OE_N <= 1'b1;
      osh_q           <= '0;
      ocnt_q          <= '0;
      RD_ADDR         <= '0;
    end
    else if (phase_q != PH_OUT)
    begin
      SERIAL_OUT_OE_N <= 1'b1;
      ocnt_q          <= '0;
      RD_ADDR         <= addr_q;
    end
    else if (fall)
    begin
      SERIAL_OUT_OE_N <= 1'b0;
      if (ocnt_q == 3'h0)
      begin
        SERIAL_OUT <= next_out[7];
        osh_q      <= {next_out[6:0], 1'b0};
        ocnt_q     <= `SFCFE_OUT_LAST;
        if (next_out == ARRAY_DATA && op_q != `SFCFE_OP_STAT_RD &&
            op_q != `SFCFE_OP_SUSP_RD && op_q != `SFCFE_OP_WAKE)
          RD_ADDR <= RD_ADDR + 24'h000001;
      end
      else
      begin
        SERIAL_OUT <= osh_q[7];
        osh_q      <= {osh_q[6:0], 1'b0};
        ocnt_q     <= ocnt_q - 3'h1;
      end
    end
    // Last address byte lands as the output phase opens
    else if (SERIAL_OUT_OE_N)
      RD_ADDR <= addr_q;
  end

  // Page data into the buffer; a refused byte spoils the frame
  assign pw_ok = WRITE_ARM_LATCH & ~busy & ~LOW_POWER;
  assign push  = byte_done & pw_ok & (idx >= `SFCFE_LEN_ADDR) &
                 ((op_q == `SFCFE_OP_PAGE_WR) | (op_q == `SFCFE_OP_PAGE_WR4));

  sfcfe_buf #(
    .W (8)
  ) u_buf (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (sh_d),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  (WR_DATA)
  );

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      ovr_q <= 1'b0;
    else if (start)
      ovr_q <= 1'b0;
    else if (push && !buf_ready)
      ovr_q <= 1'b1;
  end

  // Frame check at deselect
  always_comb
  begin
    acc        = 1'b0;
    rej        = 1'b0;
    do_exec    = 1'b0;
    do_arm     = 1'b0;
    do_disarm  = 1'b0;
    do_lp      = 1'b0;
    do_wake    = 1'b0;
    do_q_in    = 1'b0;
    do_q_out   = 1'b0;
    do_rst_arm = 1'b0;
    do_rst     = 1'b0;
    do_stat    = 1'b0;
    if (stop && nbytes != '0)
    begin
      acc = 1'b1;
      if (LOW_POWER)
      begin
        do_wake = (op_q == `SFCFE_OP_WAKE);
        rej     = ~do_wake;
      end
      else
      begin
        case (op_q)
          `SFCFE_OP_WR_ARM:     do_arm = aligned;
          `SFCFE_OP_WR_DISARM:  do_disarm = aligned;
          `SFCFE_OP_LP_ENTRY:   do_lp = aligned;
          `SFCFE_OP_STAT_STORE:
            do_stat = aligned & WRITE_ARM_LATCH & ~busy &
                      (nbytes >= `SFCFE_LEN_STAT_MIN);
          `SFCFE_OP_PAGE_WR:
            do_exec = aligned & pw_ok & ~ovr_q &
                      (nbytes >= `SFCFE_LEN_PW_MIN);
          `SFCFE_OP_PAGE_WR4:
            do_exec = aligned & pw_ok & ~ovr_q & ~FOUR_LANE_MODE &
                      (nbytes >= `SFCFE_LEN_PW_MIN);
          `SFCFE_OP_WIPE_4K,
          `SFCFE_OP_WIPE_HALF,
          `SFCFE_OP_WIPE_LARGE:
            do_exec = aligned & pw_ok &
                      (nbytes == `SFCFE_LEN_ADDR);
          `SFCFE_OP_WIPE_ALL_A,
          `SFCFE_OP_WIPE_ALL_B:
            do_exec = aligned & pw_ok & (nbytes == `SFCFE_LEN_OP);
          `SFCFE_OP_RST_ARM:    do_rst_arm = aligned;
          `SFCFE_OP_RST:        do_rst = aligned & arm_q;
          `SFCFE_OP_LANE4_IN:   do_q_in = aligned;
          `SFCFE_OP_LANE4_OUT:
            do_q_out = (bits_q == `SFCFE_LEN_FF_BITS);
          `SFCFE_OP_WAKE:       do_wake = 1'b1;
          default:              acc = 1'b1;
        endcase
        rej = ~(do_exec | do_arm | do_disarm | do_lp | do_stat |
                do_rst_arm | do_rst | do_q_in | do_q_out | do_wake) &
              (phase_q != PH_OUT) & (op_q != `SFCFE_OP_RD) &
              (out_at == '0);
      end
    end
  end

  // Mode and latch state
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      WRITE_ARM_LATCH <= 1'b0;
      LOW_POWER       <= 1'b0;
      FOUR_LANE_MODE  <= 1'b0;
      arm_q           <= 1'b0;
      stat_q          <= `SFCFE_STAT_RESET;
    end
    else if (acc)
    begin
      arm_q <= do_rst_arm;
      if (do_rst)
      begin
        WRITE_ARM_LATCH <= 1'b0;
        stat_q          <= `SFCFE_STAT_RESET;
        FOUR_LANE_MODE  <= 1'b0;
      end
      else
      begin
        if (do_arm)
          WRITE_ARM_LATCH <= 1'b1;
        else if (do_disarm || do_stat || do_exec)
          WRITE_ARM_LATCH <= 1'b0;
        if (do_stat)
          stat_q <= {dat_q[7:2], 2'b00};
        if (do_q_in)
          FOUR_LANE_MODE <= 1'b1;
        else if (do_q_out)
          FOUR_LANE_MODE <= 1'b0;
      end
      if (do_lp)
        LOW_POWER <= 1'b1;
      else if (do_wake)
        LOW_POWER <= 1'b0;
    end
  end

  // Suspend flags: a set in the clearing cycle survives
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      susp_q <= `SFCFE_STAT_RESET;
    else
      susp_q <= (do_rst ? `SFCFE_STAT_RESET : susp_q) | SUSP_SET;
  end

  // Engine hand-off and event pulses
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      EXEC_VALID  <= 1'b0;
      EXEC_OP     <= '0;
      EXEC_ADDR   <= '0;
      EXEC_STATUS <= '0;
      SOFT_RESET  <= 1'b0;
      CMD_REJECT  <= 1'b0;
    end
    else
    begin
      EXEC_VALID <= do_exec | do_stat;
      SOFT_RESET <= do_rst;
      CMD_REJECT <= rej;
      if (do_exec || do_stat)
      begin
        EXEC_OP     <= op_q;
        EXEC_ADDR   <= addr_q;
        EXEC_STATUS <= dat_q;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/sfcfe_assertions.sv
// Port checks for the command front end top.
// Assumes it is bound to sfcfe_top; one clock domain, CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_regs.svh"
module sfcfe_chk (
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  // Link and engine
  input wire logic       SPI_CS_N,
  input wire logic       SERIAL_OUT_OE_N,
  input wire logic       ENGINE_BUSY,
  input wire logic       EXEC_VALID,
  input wire logic [7:0] EXEC_OP,
  // Status
  input wire logic       WRITE_ARM_LATCH,
  input wire logic       LOW_POWER,
  input wire logic       FOUR_LANE_MODE,
  input wire logic       SOFT_RESET,
  input wire logic       CMD_REJECT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  a_oe_idle: assert property (SPI_CS_N [*6] |-> SERIAL_OUT_OE_N)
    else $error("output enabled while deselected");
  a_oe_select: assert property ($fell(SERIAL_OUT_OE_N) |-> !SPI_CS_N)
    else $error("output enabled outside a frame");
  a_exec_pulse: assert property (EXEC_VALID |-> SPI_CS_N ##1 !EXEC_VALID)
    else $error("execute is not a deselect pulse");
  a_reject_pulse: assert property (
    CMD_REJECT |-> (SPI_CS_N && !EXEC_VALID) ##1 !CMD_REJECT)
    else $error("reject is not a lone pulse");
  a_arm_deselect: assert property ($changed(WRITE_ARM_LATCH) |-> SPI_CS_N)
    else $error("arm latch moved inside a frame");
  a_mode_deselect: assert property (
    $changed(FOUR_LANE_MODE) || $changed(LOW_POWER) |-> SPI_CS_N)
    else $error("mode moved inside a frame");
  a_reset_clears: assert property (
    SOFT_RESET |-> !WRITE_ARM_LATCH && !FOUR_LANE_MODE)
    else $error("soft reset kept latch or lane mode");
  a_sleep_wake: assert property (
    EXEC_VALID && $past(LOW_POWER) |-> EXEC_OP == `SFCFE_OP_WAKE)
    else $error("command ran in low power");
  a_busy_array: assert property (
    EXEC_VALID && $past(ENGINE_BUSY) |-> !(EXEC_OP inside
      {`SFCFE_OP_PAGE_WR, `SFCFE_OP_WIPE_4K, `SFCFE_OP_STAT_STORE}))
    else $error("array command ran while busy");
endmodule

bind sfcfe_top sfcfe_chk sfcfe_chk_i (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SPI_CS_N(SPI_CS_N),
  .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .ENGINE_BUSY(ENGINE_BUSY),
  .EXEC_VALID(EXEC_VALID), .EXEC_OP(EXEC_OP), .WRITE_ARM_LATCH(WRITE_ARM_LATCH),
  .LOW_POWER(LOW_POWER), .FOUR_LANE_MODE(FOUR_LANE_MODE),
  .SOFT_RESET(SOFT_RESET), .CMD_REJECT(CMD_REJECT)
);
`default_nettype wire

// File: verif/sfcfe_host.sv
// Behavioural host controller for the serial link, mode 0, 400 ns clock.
// Assumes clk is the system clock, used only to place frame starts.
`timescale 1ns/1ps
`default_nettype none
module sfcfe_host (
  // Timing reference
  input  wire logic       clk,
  // Serial link
  output var  logic       cs_n,
  output var  logic       sck,
  output var  logic       si,
  output var  logic [2:0] dq_hi,
  input  wire logic       so
);
  initial {cs_n, sck, si, dq_hi} = 6'h20;

  // Clocks n units of d from bit 63, then reads nr bits
  task automatic xfer(input logic [63:0] d, input int n, input bit q,
                      input int nr, output logic [63:0] rd);
    rd = '0;
    @(negedge clk);
    cs_n = 1'b0;
    #200;
    for (int i = 0; i < n + nr; i++)
    begin
      if (i < n && q)
        {dq_hi, si} = d[63:60];
      else if (i < n)
        {dq_hi, si} = {~dq_hi, d[63]};
      else
        {dq_hi, si} = ~{dq_hi, si};
      d = q ? d << 4 : d << 1;
      #200;
      sck = 1'b1;
      #190;
      if (i >= n)
        rd = {rd[62:0], so};
      #10;
      sck = 1'b0;
    end
    #200;
    cs_n = 1'b1;
    {dq_hi, si} = ~{dq_hi, si};
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the command front end top.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_regs.svh"
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        busy = 1'b0;
  logic        wr_rdy = 1'b1;
  logic [7:0]  susp = 8'h00;
  logic        cs_n, sck, si, so, oe_n, ev, wv, arm, lp, qm, srst, rej;
  logic [2:0]  dq;
  logic [7:0]  eop, wd, es;
  logic [23:0] ea, ra;
  logic [63:0] rd;
  bit          s_ex, s_rej, s_rst, s_oe;
  logic [7:0]  wq[$];
  int          n_fail = 0;
  int          comparisons = 0;
  wire [7:0]   arr = ra[7:0] ^ 8'hA5;

  sfcfe_top #(.WAKE_ID(8'h3C)) sfcfe_top_i (
    .CLK_SYS(clk), .RST_N(rst_n), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SERIAL_IN_LINE(si),
    .DQ_HI_IN(dq), .SERIAL_OUT(so), .SERIAL_OUT_OE_N(oe_n), .ENGINE_BUSY(busy),
    .EXEC_VALID(ev), .EXEC_OP(eop), .EXEC_ADDR(ea), .EXEC_STATUS(es), .WR_VALID(wv),
    .WR_READY(wr_rdy), .WR_DATA(wd), .RD_ADDR(ra), .ARRAY_DATA(arr), .SUSP_SET(susp),
    .WRITE_ARM_LATCH(arm), .LOW_POWER(lp), .FOUR_LANE_MODE(qm), .SOFT_RESET(srst),
    .CMD_REJECT(rej));
  sfcfe_host host_i (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .dq_hi(dq), .so(so));

  always #25 clk = ~clk;

  // Sticky pulse flags and drained page bytes
  always @(posedge clk)
  begin
    s_ex |= (ev === 1'b1);
    s_rej |= (rej === 1'b1);
    s_rst |= (srst === 1'b1);
    s_oe |= (oe_n === 1'b0);
    if (wv === 1'b1 && wr_rdy === 1'b1)
      wq.push_back(wd);
  end

  task automatic chk(input string what, input logic [63:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic send(input logic [63:0] d, input int n, bit q = 0, int nr = 0);
    s_ex = 0;
    s_rej = 0;
    s_rst = 0;
    s_oe = 0;
    host_i.xfer(d, n, q, nr, rd);
    repeat (12) @(negedge clk);
  endtask

  task automatic op(input logic [7:0] c);
    send({c, 56'h0}, 8);
  endtask

  task automatic t_arm();
    op(`SFCFE_OP_WR_ARM);
    chk("arm set", 1, arm);
    send({`SFCFE_OP_STAT_RD, 56'h0}, 8, 0, 16);
    chk("status", 16'h0202, rd);
    chk("out enable", {1'b1, 1'b1}, {s_oe, oe_n});
    op(`SFCFE_OP_WR_DISARM);
    chk("arm cleared", 0, arm);
    chk("no out enable", 0, s_oe);
    send({`SFCFE_OP_WR_ARM, 56'h0}, 9);
    chk("odd count", {1'b1, 1'b0}, {s_rej, arm});
    op(`SFCFE_OP_WR_ARM);
    send({`SFCFE_OP_STAT_STORE, 8'hA8, 48'h0}, 16);
    send({`SFCFE_OP_STAT_RD, 56'h0}, 8, 0, 8);
    chk("stored status", 8'hA8, rd);
    chk("store byte", 8'hA8, es);
  endtask

  task automatic t_page();
    op(`SFCFE_OP_WR_ARM);
    wr_rdy = 0;
    wq.delete();
    send({`SFCFE_OP_PAGE_WR, 24'h012345, 16'hC33C, 16'h0}, 48);
    chk("page run", {1'b1, 1'b0}, {s_ex, arm});
    chk("page addr", {8'h02, 24'h012345}, {eop, ea});
    wr_rdy = 1;
    repeat (8) @(negedge clk);
    chk("page data", {32'h2, 16'hC33C}, {wq.size(), wq[0], wq[1]});
    op(`SFCFE_OP_WR_ARM);
    send({`SFCFE_OP_PAGE_WR, 56'h0}, 32);
    chk("short page", {1'b0, 1'b1}, {s_ex, arm});
    send({`SFCFE_OP_PAGE_WR, 24'h0, 8'hAA, 24'h0}, 44);
    chk("split byte", {1'b0, 1'b1}, {s_ex, arm});
    op(`SFCFE_OP_WR_DISARM);
  endtask

  task automatic t_wipe();
    logic [7:0] w[5] = '{`SFCFE_OP_WIPE_4K, `SFCFE_OP_WIPE_HALF, `SFCFE_OP_WIPE_LARGE,
                         `SFCFE_OP_WIPE_ALL_A, `SFCFE_OP_WIPE_ALL_B};
    for (int i = 0; i < 5; i++)
    begin
      op(`SFCFE_OP_WR_ARM);
      if (i < 3)
      begin
        send({w[i], 24'h000800, 32'h0}, 24);
        chk("wipe short", {1'b0, 1'b1}, {s_ex, arm});
        send({w[i], 24'h000800, 32'h0}, 40);
        chk("wipe long", {1'b0, 1'b1}, {s_ex, arm});
      end
      send({w[i], 24'h000800, 32'h0}, i < 3 ? 32 : 8);
      chk("wipe run", {1'b1, 1'b0, w[i]}, {s_ex, arm, eop});
    end
    op(`SFCFE_OP_WR_ARM);
    busy = 1;
    send({`SFCFE_OP_STAT_RD, 56'h0}, 8, 0, 8);
    chk("busy status", 8'hAB, rd);
    send({`SFCFE_OP_WIPE_4K, 56'h0}, 32);
    chk("busy wipe", 0, s_ex);
    op(`SFCFE_OP_WR_DISARM);
    busy = 0;
    op(`SFCFE_OP_WR_DISARM);
  endtask

  task automatic t_reset();
    susp = 8'h81;
    @(negedge clk);
    susp = 8'h00;
    send({`SFCFE_OP_SUSP_RD, 56'h0}, 8, 0, 16);
    chk("suspend", 16'h8181, rd);
    op(`SFCFE_OP_RST_ARM);
    op(`SFCFE_OP_WR_ARM);
    op(`SFCFE_OP_RST);
    chk("reset cancelled", {1'b0, 1'b1}, {s_rst, arm});
    op(`SFCFE_OP_RST_ARM);
    op(`SFCFE_OP_RST);
    chk("reset run", {1'b1, 1'b0}, {s_rst, arm});
    send({`SFCFE_OP_SUSP_RD, 56'h0}, 8, 0, 8);
    chk("suspend zero", 0, rd);
    send({`SFCFE_OP_STAT_RD, 56'h0}, 8, 0, 8);
    chk("status zero", 0, rd);
  endtask

  task automatic t_mode();
    op(`SFCFE_OP_LANE4_IN);
    chk("four lane", 1, qm);
    send({`SFCFE_OP_WR_ARM, 56'h0}, 2, 1);
    chk("quad arm", 1, arm);
    send({`SFCFE_OP_LANE4_OUT, 56'h0}, 2, 1);
    chk("lane exit", 0, qm);
    op(`SFCFE_OP_WR_DISARM);
    op(`SFCFE_OP_LP_ENTRY);
    chk("sleep", 1, lp);
    op(`SFCFE_OP_WR_ARM);
    chk("sleep refuses", {1'b1, 1'b0}, {s_rej, arm});
    op(`SFCFE_OP_WAKE);
    chk("woken", 0, lp);
    send({`SFCFE_OP_WAKE, 56'h0}, 32, 0, 16);
    chk("wake id", 16'h3C3C, rd);
    send({`SFCFE_OP_RD, 24'h000010, 32'h0}, 32, 0, 16);
    chk("read", 16'hB5B4, rd);
    send({`SFCFE_OP_RD_FAST, 24'h0000F0, 32'h0}, 40, 0, 16);
    chk("fast read", 16'h5554, rd);
  endtask

  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    t_arm();
    t_page();
    t_wipe();
    t_reset();
    t_mode();
    stop_test();
  end

  // Run needs about 8700 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("[FAIL] watchdog expected done seen hang");
    stop_test();
  end
endmodule
`default_nettype wire
